/* include/uart_status_defs.vh */
// Offsets, field positions, reset values and timing counts
`ifndef UART_STATUS_DEFS_VH
`define UART_STATUS_DEFS_VH
// ****************************************
// Register offsets on the 8-bit host bus
// ****************************************
`define OFS_RX_DATA 3'h0
`define OFS_EXTRA_FEATURE 3'h3
`define OFS_LINE_STATUS 3'h5
`define OFS_MODEM_STATUS 3'h6
`define OFS_IR_WIDTH 3'h7
// ****************************************
// Field positions
// ****************************************
`define MODEM_CTL_DTR 0
`define MODEM_CTL_RTS 1
`define MODEM_CTL_OUT1 2
`define MODEM_CTL_OUT2 3
`define MODEM_CTL_LOOP 4
`define MODEM_CTL_IR 6
`define INT_EN_LINE 2
`define INT_EN_MODEM 3
`define ENH_ENABLE 4
`define ENH_AUTO_RTS 6
`define ENH_AUTO_CTS 7
`define XF_HALF_DUPLEX 0
`define XF_IR_INVERT 1
`define XF_AUTO_DIR 2
`define XF_ERR_NOW 3
`define XF_XON_ANY 4
`define XF_DIR_INVERT 5
`define XF_WIDTH 6
`define LS_TX_EMPTY 6
`define LS_FIFO_ERR 7
// ****************************************
// Reset values and timing counts
// ****************************************
`define XF_RESET 6'h00
`define IR_WIDTH_RESET 8'h00
`define IR_DEFAULT_TICKS 8'h03
`define IR_BIT_TICKS 5'h10
`endif

/* logic/status_fifo.v */
// Receive FIFO with registered read data
module status_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  input wire clk_en,
  // Filling side
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push = in_valid & in_ready;
  wire load = (count != {(AW+1){1'b0}}) & (~out_valid | out_ready);
  wire [AW:0] next_count = count + {{AW{1'b0}}, push}
    - {{AW{1'b0}}, load};

  always @(posedge mclk) begin
    if (clk_en && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (load) begin
        out_data <= mem[rd_ptr];
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count <= next_count;
      // Registered so the source sees a clean stall
      in_ready <= (next_count < DEPTH);
    end
  end
endmodule // status_fifo

/* logic/ir_pulse.v */
// Infrared pulse encoder and decoder
`include "uart_status_defs.vh"
module ir_pulse (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  input wire clk_en,
  // Bit timing from the baud generator
  input wire tick16,
  input wire bit_start,
  // Transmit side
  input wire tx_bit,
  input wire [7:0] width,
  output reg ir_tx,
  // Receive side, already polarity corrected and gated
  input wire rx_pulse,
  output reg rx_bit
);
  reg [7:0] enc_cnt;
  reg [4:0] dec_cnt;
  reg rx_prev;
  wire dflt = (width == 8'h00);

  always @(posedge mclk) begin
    if (!rst_n) begin
      ir_tx <= 1'b0;
      enc_cnt <= 8'h00;
      rx_bit <= 1'b1;
      dec_cnt <= 5'h00;
      // A pulse already high out of reset is not an edge
      rx_prev <= 1'b1;
    end else if (clk_en) begin
      if (bit_start && !tx_bit) begin
        ir_tx <= 1'b1;
        enc_cnt <= dflt ? `IR_DEFAULT_TICKS : width;
      end else if (ir_tx && (!dflt || tick16)) begin
        if (enc_cnt <= 8'h01) begin
          ir_tx <= 1'b0;
        end
        enc_cnt <= enc_cnt - 8'h01;
      end
      rx_prev <= rx_pulse;
      // One pulse marks a whole zero bit cell
      if (rx_pulse && !rx_prev) begin
        rx_bit <= 1'b0;
        dec_cnt <= `IR_BIT_TICKS;
      end else if (!rx_bit && tick16) begin
        if (dec_cnt == 5'h01) begin
          rx_bit <= 1'b1;
        end
        dec_cnt <= dec_cnt - 5'h01;
      end
    end
  end
endmodule // ir_pulse

/* logic/uart_status_extra.v */
// Status and extra-feature logic of the UART
`include "uart_status_defs.vh"
module uart_status_extra #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock, enable and reset
  input wire mclk,
  input wire clk_en,
  input wire rst_n,
  // Host register port
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Control registers held in the wider UART
  input wire [7:0] modem_control,
  input wire [7:0] interrupt_enable,
  input wire [7:0] enhanced_feature_control,
  input wire [5:0] line_status_low,
  input wire sw_flow_active,
  input wire auto_rts_n,
  // Transmitter status and serial data
  input wire tx_hold_empty,
  input wire tx_shift_empty,
  input wire tx_serial,
  input wire tick16,
  input wire tx_bit_start,
  // Received characters: data plus break, framing, parity
  input wire rx_char_valid,
  input wire [7:0] rx_char_data,
  input wire [2:0] rx_char_err,
  output reg rx_char_ready,
  // Serial and modem pins
  input wire rx_pin,
  input wire cts_n,
  input wire dsr_n,
  input wire ring_indicator_in_n,
  input wire carrier_detect_in_n,
  output reg tx_pin,
  output reg rts_n,
  // Results to the wider UART
  output reg rx_serial,
  output reg tx_enable,
  output reg xon_resume,
  output reg line_irq,
  output reg modem_irq
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [4:0] pins_raw = {rx_pin, carrier_detect_in_n,
    ring_indicator_in_n, dsr_n, cts_n};
  reg [4:0] pins_meta;
  reg [4:0] pins_sync;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge mclk) begin
        if (!rst_n) begin
          pins_meta[gi] <= 1'b1;
          pins_sync[gi] <= 1'b1;
        end else if (clk_en) begin
          pins_meta[gi] <= pins_raw[gi];
          pins_sync[gi] <= pins_meta[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Decode and feature registers
  // ****************************************
  reg [`XF_WIDTH-1:0] extra_feature_control;
  reg [7:0] infrared_pulse_width;
  wire enh_en = enhanced_feature_control[`ENH_ENABLE];
  wire wr_xf = reg_wr && (reg_addr == `OFS_EXTRA_FEATURE);
  wire wr_infrared_pulse_width = reg_wr && (reg_addr == `OFS_IR_WIDTH);
  wire rd_data = reg_rd && (reg_addr == `OFS_RX_DATA);
  wire rd_ls = reg_rd && (reg_addr == `OFS_LINE_STATUS);
  wire rd_ms = reg_rd && (reg_addr == `OFS_MODEM_STATUS);

  wire half_dup = extra_feature_control[`XF_HALF_DUPLEX];
  wire ir_inv = extra_feature_control[`XF_IR_INVERT];
  wire auto_dir = extra_feature_control[`XF_AUTO_DIR];
  wire err_now = extra_feature_control[`XF_ERR_NOW];
  wire xon_any = extra_feature_control[`XF_XON_ANY];
  wire dir_inv = extra_feature_control[`XF_DIR_INVERT];
  wire ir_mode = modem_control[`MODEM_CTL_IR];
  wire loop = modem_control[`MODEM_CTL_LOOP];

  always @(posedge mclk) begin
    if (!rst_n) begin
      extra_feature_control <= `XF_RESET;
      infrared_pulse_width <= `IR_WIDTH_RESET;
    end else if (clk_en) begin
      // Legacy software cannot disturb latched settings
      if (wr_xf && enh_en) begin
        // Bits 7:6 are not stored at all
        extra_feature_control <= reg_wdata[`XF_WIDTH-1:0];
      end
      if (wr_infrared_pulse_width && enh_en) begin
        infrared_pulse_width <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Receive FIFO with error bookkeeping
  // ****************************************
  wire fifo_in_ready;
  wire head_valid;
  wire [10:0] head;
  wire push = rx_char_valid && rx_char_ready;
  wire pop = rd_data && head_valid;
  wire push_bad = push && (rx_char_err != 3'h0);
  wire pop_bad = pop && (head[10:8] != 3'h0);
  reg [FIFO_AW:0] bad_count;

  status_fifo #(
    .WIDTH(11),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({rx_char_err, rx_char_data}),
    .out_valid(head_valid),
    .out_ready(rd_data),
    .out_data(head)
  );

  always @(posedge mclk) begin
    if (!rst_n) begin
      bad_count <= {(FIFO_AW+1){1'b0}};
      rx_char_ready <= 1'b0;
    end else if (clk_en) begin
      // No back-to-back takes, so a high ready always has room
      rx_char_ready <= fifo_in_ready && !push;
      if (push_bad && !pop_bad) begin
        bad_count <= bad_count + {{FIFO_AW{1'b0}}, 1'b1};
      end else if (pop_bad && !push_bad) begin
        bad_count <= bad_count - {{FIFO_AW{1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************
  // Bad-data interrupt timing
  // ****************************************
  reg head_valid_d;
  reg pop_d;
  reg bad_flag;
  // A new head appears after a pop or after the FIFO was empty
  wire head_new = head_valid && (!head_valid_d || pop_d);
  wire head_bad = head_new && (head[10:8] != 3'h0);
  wire bad_set = head_bad || (err_now && push_bad);

  always @(posedge mclk) begin
    if (!rst_n) begin
      head_valid_d <= 1'b0;
      pop_d <= 1'b0;
      bad_flag <= 1'b0;
    end else if (clk_en) begin
      head_valid_d <= head_valid;
      pop_d <= pop;
      // Set wins over a line status read in the same cycle
      if (bad_set) begin
        bad_flag <= 1'b1;
      end else if (rd_ls) begin
        bad_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Modem status and change flags
  // ****************************************
  // Order: clear-to-send, data-set-ready, ring, carrier
  wire [3:0] pin_level = ~pins_sync[3:0];
  wire [3:0] loop_level = {modem_control[`MODEM_CTL_OUT2],
    modem_control[`MODEM_CTL_OUT1], modem_control[`MODEM_CTL_DTR],
    modem_control[`MODEM_CTL_RTS]};
  wire [3:0] next_level = loop ? loop_level : pin_level;
  reg [3:0] level;
  reg [3:0] delta;
  wire [3:0] change;
  assign change[0] = level[0] ^ next_level[0];
  assign change[1] = level[1] ^ next_level[1];
  // Status bit falls when the ring pin rises: end of ringing
  assign change[2] = level[2] & ~next_level[2];
  assign change[3] = level[3] ^ next_level[3];

  always @(posedge mclk) begin
    if (!rst_n) begin
      level <= 4'h0;
      delta <= 4'h0;
    end else if (clk_en) begin
      level <= next_level;
      // An edge in the read cycle survives the clear
      delta <= (rd_ms ? 4'h0 : delta) | change;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  wire tx_idle = tx_hold_empty && tx_shift_empty;
  wire [7:0] line_status = {(bad_count != {(FIFO_AW+1){1'b0}}),
    tx_idle, line_status_low};
  wire [7:0] modem_line_status = {level, delta};
  reg [7:0] next_rdata;

  always @* begin
    case (reg_addr)
      `OFS_RX_DATA: next_rdata = head[7:0];
      `OFS_LINE_STATUS: next_rdata = line_status;
      `OFS_MODEM_STATUS: next_rdata = modem_line_status;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Interrupts to the wider UART
  // ****************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      line_irq <= 1'b0;
      modem_irq <= 1'b0;
    end else if (clk_en) begin
      line_irq <= interrupt_enable[`INT_EN_LINE] && bad_flag;
      modem_irq <= interrupt_enable[`INT_EN_MODEM]
        && (delta != 4'h0);
    end
  end

  // ****************************************
  // Flow control
  // ****************************************
  wire cts_stop = !level[0];

  always @(posedge mclk) begin
    if (!rst_n) begin
      tx_enable <= 1'b1;
      xon_resume <= 1'b0;
    end else if (clk_en) begin
      if (!enhanced_feature_control[`ENH_AUTO_CTS] || !cts_stop) begin
        tx_enable <= 1'b1;
      end else if (tx_shift_empty) begin
        // Only between characters, so the one in flight ends
        tx_enable <= 1'b0;
      end
      xon_resume <= xon_any && sw_flow_active && push;
    end
  end

  // ****************************************
  // Direction control and request-to-send
  // ****************************************
  wire manual_rts_n = !modem_control[`MODEM_CTL_RTS];
  wire normal_rts_n = enhanced_feature_control[`ENH_AUTO_RTS]
    ? auto_rts_n : manual_rts_n;
  // Inverted direction only acts once software asserts the pin
  wire dir_ok = !dir_inv || !manual_rts_n;
  wire dir_level = dir_inv ? tx_idle : !tx_idle;

  always @(posedge mclk) begin
    if (!rst_n) begin
      rts_n <= 1'b1;
    end else if (clk_en) begin
      if (auto_dir && dir_ok) begin
        rts_n <= dir_level;
      end else begin
        rts_n <= normal_rts_n;
      end
    end
  end

  // ****************************************
  // Infrared path
  // ****************************************
  wire ir_tx;
  wire ir_rx_bit;
  // Muted receiver stops the UART hearing its own echo
  wire ir_rx_pulse = (pins_sync[4] ^ ir_inv)
    && !(half_dup && !tx_idle);

  ir_pulse u_ir (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .tick16(tick16),
    .bit_start(tx_bit_start),
    .tx_bit(tx_serial),
    .width(infrared_pulse_width),
    .ir_tx(ir_tx),
    .rx_pulse(ir_rx_pulse),
    .rx_bit(ir_rx_bit)
  );

  always @(posedge mclk) begin
    if (!rst_n) begin
      tx_pin <= 1'b1;
      rx_serial <= 1'b1;
    end else if (clk_en) begin
      tx_pin <= ir_mode ? ir_tx : tx_serial;
      rx_serial <= ir_mode ? ir_rx_bit : pins_sync[4];
    end
  end
endmodule // uart_status_extra

/* tb/status_checker.sv */
// Assertion checker for the status and extra-feature block
`include "uart_status_defs.vh"
module status_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Host side
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] modem_control,
  input wire logic [7:0] interrupt_enable,
  input wire logic [7:0] enhanced_feature_control,
  // Data and pins
  input wire logic tx_hold_empty,
  input wire logic tx_shift_empty,
  input wire logic tx_serial,
  input wire logic rx_char_valid,
  input wire logic rx_char_ready,
  input wire logic [2:0] rx_char_err,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ring_indicator_in_n,
  input wire logic carrier_detect_in_n,
  input wire logic tx_pin,
  input wire logic rts_n,
  input wire logic line_irq,
  input wire logic modem_irq
);
  // ****************************************
  // Shadow state and properties
  // ****************************************
  logic [5:0] xf;
  logic rd6;
  logic busy;
  logic [2:0] mpins;
  assign rd6 = clk_en && reg_rd && reg_addr == `OFS_MODEM_STATUS;
  assign busy = !(tx_hold_empty && tx_shift_empty);
  assign mpins = {carrier_detect_in_n, dsr_n, cts_n};
  // Feature bits are write-only, so keep our own copy
  always @(posedge mclk) begin
    if (!rst_n)
      xf <= 6'h00;
    else if (clk_en && reg_wr && reg_addr == `OFS_EXTRA_FEATURE &&
        enhanced_feature_control[`ENH_ENABLE])
      xf <= reg_wdata[5:0];
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_quiet;
    $stable({mpins, ring_indicator_in_n, modem_control, interrupt_enable});
  endsequence
  a_loop_map: assert property (
    $stable(modem_control)[*4] ##0 (rd6 && modem_control[4]) |=>
    reg_rdata[7:4] == {$past(modem_control[3:2]), $past(modem_control[0]),
    $past(modem_control[1])})
    else $error("loopback status bits wrong");
  a_tx_empty: assert property (
    ($stable(tx_hold_empty) && $stable(tx_shift_empty))[*3] ##0
    (clk_en && reg_rd && reg_addr == `OFS_LINE_STATUS) |=>
    reg_rdata[`LS_TX_EMPTY] == !$past(busy))
    else $error("transmitter empty flag wrong");
  a_irq_gate: assert property (
    modem_irq |-> $past(interrupt_enable[`INT_EN_MODEM]))
    else $error("modem interrupt while disabled");
  a_flag_clear: assert property (
    s_quiet[*5] ##0 rd6 ##1 s_quiet[*2] |-> !modem_irq)
    else $error("modem interrupt kept after status read");
  a_irq_set: assert property (
    ($changed(mpins) || $rose(ring_indicator_in_n)) &&
    interrupt_enable[`INT_EN_MODEM] && !modem_control[`MODEM_CTL_LOOP]
    |-> ##[1:8] modem_irq)
    else $error("modem change raised no interrupt");
  a_ring_start: assert property (
    ($fell(ring_indicator_in_n) && !modem_irq) ##1 s_quiet[*7] |-> !modem_irq)
    else $error("start of ringing set a change flag");
  a_auto_dir: assert property (
    (xf[2] && !(xf[5] && !modem_control[1]) && !modem_control[4] &&
    $stable({xf, busy, modem_control}))[*3] |-> rts_n == (busy ^ xf[5]))
    else $error("direction output wrong");
  a_tx_route: assert property (
    (!modem_control[6] && !modem_control[4] && $stable(tx_serial))[*3]
    |-> tx_pin == tx_serial)
    else $error("serial output not routed");
  a_bad_now: assert property (
    clk_en && rx_char_valid && rx_char_ready && (|rx_char_err) && xf[3] &&
    interrupt_enable[`INT_EN_LINE] |-> ##[1:4] line_irq)
    else $error("bad character raised no interrupt");
  c_loop: cover property (rd6 && modem_control[4]);
  c_modem_irq: cover property ($rose(modem_irq));
  c_full: cover property (rx_char_valid && !rx_char_ready);
endmodule // status_checker
bind uart_status_extra status_checker i_chk (.mclk, .rst_n, .clk_en,
  .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .modem_control,
  .interrupt_enable, .enhanced_feature_control, .tx_hold_empty,
  .tx_shift_empty, .tx_serial, .rx_char_valid, .rx_char_ready, .rx_char_err,
  .cts_n, .dsr_n, .ring_indicator_in_n, .carrier_detect_in_n, .tx_pin,
  .rts_n, .line_irq, .modem_irq);

/* tb/far_end.sv */
// Far-end model: modem pins and serial receive line
module far_end (
  // Clock
  input wire logic mclk,
  // Wanted levels {rx, carrier, ring, dsr, cts}
  input wire logic [4:0] want,
  // Pins toward the block, idle high
  output logic [4:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = 5'h1f;
  // Pins move just after an edge, like a clocked remote
  always @(posedge mclk) begin
    pins <= #5 want;
  end
endmodule // far_end

/* tb/uart_status_extra_tb_top.sv */
// Testbench for the status and extra-feature block
`include "uart_status_defs.vh"
module uart_status_extra_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tick16 = 1'b0, tx_bit_start = 1'b0;
  logic [7:0] reg_wdata = 8'h00, modem_control = 8'h00, rd_val;
  logic [7:0] interrupt_enable = 8'h00, enhanced_feature_control = 8'h00;
  logic sw_flow_active = 1'b0, tx_hold_empty = 1'b1, tx_shift_empty = 1'b1;
  logic tx_serial = 1'b1, rx_char_valid = 1'b0, ok, seen;
  logic [7:0] rx_char_data = 8'h00;
  logic [2:0] rx_char_err = 3'h0;
  logic [4:0] want = 5'h1f;
  logic [5:0] tcnt = 6'h00;
  logic [7:0] lb [4] = '{8'h20, 8'h10, 8'h40, 8'h80};
  wire [4:0] pv;
  wire [7:0] reg_rdata;
  wire rx_char_ready, tx_pin, rts_n, rx_serial, tx_enable, xon_resume;
  wire line_irq, modem_irq;
  int err_total = 0, checks_done = 0, n, len;
  // ****************************************
  // Clock, ticks, design and far end
  // ****************************************
  always #50 mclk = ~mclk;
  // Tick every 4 cycles, bit start every 16 ticks
  always @(posedge mclk) begin
    tcnt <= #5 tcnt + 6'h01;
    tick16 <= #5 (tcnt[1:0] == 2'h3);
    tx_bit_start <= #5 (tcnt == 6'h3f);
  end
  uart_status_extra i_dut (.mclk, .clk_en, .rst_n, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .modem_control, .interrupt_enable,
    .enhanced_feature_control, .line_status_low(6'h00), .sw_flow_active,
    .auto_rts_n(1'b1), .tx_hold_empty, .tx_shift_empty, .tx_serial, .tick16,
    .tx_bit_start, .rx_char_valid, .rx_char_data, .rx_char_err,
    .rx_char_ready, .rx_pin(pv[4]), .cts_n(pv[0]), .dsr_n(pv[1]),
    .ring_indicator_in_n(pv[2]), .carrier_detect_in_n(pv[3]), .tx_pin,
    .rts_n, .rx_serial, .tx_enable, .xon_resume, .line_irq, .modem_irq);
  far_end i_far (.mclk, .want, .pins(pv));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp);
    checks_done++;
    if (seen_v !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen_v, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #5;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk) #5;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk) #5;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk) #5;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk) #5;
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask
  // Ready lags the FIFO by a cycle, so one push per two edges
  task automatic push(input logic [7:0] d, input logic [2:0] e);
    @(posedge mclk) #5;
    rx_char_valid = 1'b1;
    rx_char_data = d;
    rx_char_err = e;
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      ok = rx_char_ready;
      @(posedge mclk) #5;
    end
    rx_char_valid = 1'b0;
  endtask
  task automatic pulse();
    len = 0;
    for (int i = 0; i < 300 && tx_pin !== 1'b1; i++) @(posedge mclk) #5;
    while (tx_pin === 1'b1 && len < 300) begin
      @(posedge mclk) #5;
      len++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000;
    err_total++;
    end_of_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5) @(posedge mclk);
    #5 rst_n = 1'b1;
    cyc(4);
    rd(`OFS_MODEM_STATUS);
    rd(`OFS_MODEM_STATUS);
    check(rd_val, 8'h00);
    rd(`OFS_LINE_STATUS);
    check(rd_val, 8'h40);
    rd(3'h1);
    check(rd_val, 8'h00);
    interrupt_enable = 8'h08;
    for (int i = 0; i < 4; i++) begin
      want[i] = 1'b0;
      cyc(8);
      check({7'h0, modem_irq}, (i == 2) ? 8'h00 : 8'h01);
      rd(`OFS_MODEM_STATUS);
      check(rd_val, (8'h10 << i) | ((i == 2) ? 8'h00 : (8'h01 << i)));
      want[i] = 1'b1;
      cyc(8);
      rd(`OFS_MODEM_STATUS);
      check(rd_val, 8'h01 << i);
      cyc(2);
      check({7'h0, modem_irq}, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      modem_control = 8'h10 | (8'h01 << i);
      cyc(6);
      rd(`OFS_MODEM_STATUS);
      check(rd_val & 8'hf0, lb[i]);
    end
    modem_control = 8'h00;
    $display("test modem status done");
    wr(`OFS_EXTRA_FEATURE, 8'h04);
    cyc(4);
    check({7'h0, rts_n}, 8'h01);
    enhanced_feature_control = 8'h10;
    wr(`OFS_EXTRA_FEATURE, 8'hc4);
    cyc(4);
    check({7'h0, rts_n}, 8'h00);
    tx_hold_empty = 1'b0;
    cyc(4);
    check({7'h0, rts_n}, 8'h01);
    rd(`OFS_LINE_STATUS);
    check(rd_val, 8'h00);
    modem_control = 8'h02;
    wr(`OFS_EXTRA_FEATURE, 8'h24);
    cyc(4);
    check({7'h0, rts_n}, 8'h00);
    tx_hold_empty = 1'b1;
    cyc(4);
    check({7'h0, rts_n}, 8'h01);
    modem_control = 8'h00;
    $display("test direction control done");
    interrupt_enable = 8'h04;
    wr(`OFS_EXTRA_FEATURE, 8'h08);
    push(8'h5a, 3'h1);
    cyc(3);
    check({7'h0, line_irq}, 8'h01);
    rd(`OFS_LINE_STATUS);
    check(rd_val, 8'hc0);
    rd(`OFS_RX_DATA);
    check(rd_val, 8'h5a);
    rd(`OFS_LINE_STATUS);
    check(rd_val, 8'h40);
    cyc(2);
    check({7'h0, line_irq}, 8'h00);
    sw_flow_active = 1'b1;
    wr(`OFS_EXTRA_FEATURE, 8'h10);
    seen = 1'b0;
    fork
      push(8'h33, 3'h0);
      repeat (8) begin
        @(posedge mclk) #5;
        seen = seen | xon_resume;
      end
    join
    check({7'h0, seen}, 8'h01);
    rd(`OFS_RX_DATA);
    sw_flow_active = 1'b0;
    n = 0;
    ok = 1'b1;
    while (ok && n < 20) begin
      push(n[7:0], 3'h0);
      if (ok) n++;
    end
    check(n[7:0], 8'h11);
    for (int i = 0; i < 17; i++) begin
      rd(`OFS_RX_DATA);
      check(rd_val, i[7:0]);
    end
    $display("test receive buffer done");
    enhanced_feature_control = 8'h90;
    want[0] = 1'b1;
    cyc(6);
    check({7'h0, tx_enable}, 8'h00);
    want[0] = 1'b0;
    cyc(6);
    check({7'h0, tx_enable}, 8'h01);
    // Frozen enable: the stop request must wait for the enable
    clk_en = 1'b0;
    want[0] = 1'b1;
    cyc(8);
    check({7'h0, tx_enable}, 8'h01);
    clk_en = 1'b1;
    cyc(6);
    check({7'h0, tx_enable}, 8'h00);
    want[0] = 1'b0;
    cyc(6);
    check({7'h0, tx_enable}, 8'h01);
    enhanced_feature_control = 8'h10;
    modem_control = 8'h40;
    wr(`OFS_IR_WIDTH, 8'h05);
    tx_serial = 1'b0;
    pulse();
    pulse();
    check(len[7:0], 8'h05);
    wr(`OFS_IR_WIDTH, 8'h00);
    pulse();
    pulse();
    check({7'h0, len >= 9 && len <= 13}, 8'h01);
    wr(`OFS_EXTRA_FEATURE, 8'h02);
    cyc(40);
    check({7'h0, rx_serial}, 8'h01);
    // Inverted input: a low pulse must decode as a zero
    want[4] = 1'b0;
    cyc(8);
    check({7'h0, rx_serial}, 8'h00);
    want[4] = 1'b1;
    modem_control = 8'h00;
    tx_serial = 1'b1;
    cyc(4);
    check({7'h0, tx_pin}, 8'h01);
    $display("test infrared done");
    end_of_test();
  end
endmodule // uart_status_extra_tb_top
